// File: pkg/tpr_regs.svh
// register offsets, field positions, reset values and timing counts of the transcoder path router
`ifndef TPR_REGS_SVH
`define TPR_REGS_SVH

`define TPR_OFS_IN_CFG     8'hB0
`define TPR_OFS_IN_GAIN    8'hB1
`define TPR_OFS_OUT_CFG    8'hB3
`define TPR_OFS_LINE_GAIN  8'hB4
`define TPR_OFS_MON_GAIN   8'hB5
`define TPR_OFS_SPK_GAIN   8'hB6
`define TPR_OFS_CTRL       8'hC0

// input_route_config fields
`define TPR_IN_SRC_LSB     0
`define TPR_IN_ADC_SEL_BIT 2
`define TPR_IN_PDN_LSB     3
// output_route_config fields
`define TPR_OUT_DAC0_LSB   0
`define TPR_OUT_DAC1_LSB   4
`define TPR_OUT_PDN_LSB    8
// path control fields
`define TPR_CTRL_DUPLEX    0
`define TPR_CTRL_OP_LSB    1
`define TPR_CTRL_PORT_LSB  3
`define TPR_CTRL_LAW_BIT   6
`define TPR_CTRL_HOLD_BIT  7

`define TPR_IN_CFG_RST     16'h0018
`define TPR_OUT_CFG_RST    16'h0F00
`define TPR_CTRL_RST       16'h0088
`define TPR_GAIN_RST       16'h0000

// host side register map
`define TPR_H_TARGET       8'h00
`define TPR_H_WDATA        8'h01
`define TPR_H_AUDIO        8'h02
`define TPR_H_STATUS       8'h03
`define TPR_H_BOOTSEL      8'h04
`define TPR_H_BOOTSEL_RST  2'h3

`define TPR_CLK_NS         4
`define TPR_SPI_HALF_NS    8
`define TPR_SPI_HALF_CYC   ((`TPR_SPI_HALF_NS + `TPR_CLK_NS - 1) / `TPR_CLK_NS)
`define TPR_FI_WORDS       64

`endif

// File: pkg/tpr_pkg.sv
// types used by the device end of the transcoder path router and by the bench
`default_nettype none
package tpr_pkg;
  typedef enum logic [1:0] {
    TPR_OP_ENC   = 2'h0,
    TPR_OP_DEC   = 2'h1,
    TPR_OP_TRANS = 2'h2
  } tpr_op_e;

  typedef enum logic [1:0] {
    TPR_SRC_HOST = 2'h0,
    TPR_SRC_PCM  = 2'h1,
    TPR_SRC_ANA  = 2'h2
  } tpr_src_e;

  typedef enum logic [1:0] {
    TPR_ST_STRAP    = 2'h0,
    TPR_ST_LOADHOST = 2'h1,
    TPR_ST_LOADMEM  = 2'h2,
    TPR_ST_RUN      = 2'h3
  } tpr_state_e;
endpackage
`default_nettype wire

// File: pkg/tpr_link_if.sv
// link between the host controller end and the transcoder device end
`default_nettype none
interface tpr_link_if;
  logic        cfg_wr;
  logic [7:0]  cfg_addr;
  logic [15:0] cfg_data;
  logic        word_valid;
  logic [15:0] word_data;
  logic        word_ready;
  logic        boot_sel_high;
  logic        boot_sel_low;
  logic        dev_running;
  logic        cfg_err;

  modport dev  (input  cfg_wr, cfg_addr, cfg_data, word_valid, word_data, boot_sel_high, boot_sel_low,
                output word_ready, dev_running, cfg_err);
  modport host (output cfg_wr, cfg_addr, cfg_data, word_valid, word_data, boot_sel_high, boot_sel_low,
                input  word_ready, dev_running, cfg_err);
endinterface
`default_nettype wire

// File: logic/tpr_device.sv
// transcoder device end: word fifo, boot pin sharing, routing and mode control
//
// Added by the designer: the address-and-strobe port.
`include "tpr_regs.svh"
`default_nettype none

// ----------------------------------------
// word fifo
// ----------------------------------------
module tpr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clock_in,
  input  wire logic             rstn_in,
  // fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign out_data_out  = mem_r[rd_ptr_r];

  always_ff @(posedge clock_in)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------
// device end
// ----------------------------------------
module tpr_device #(
  parameter int FI_WORDS = `TPR_FI_WORDS
) (
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // link to host
  tpr_link_if.dev          link,
  // shared serial memory / pcm pins
  output logic             mem_sclk_out,
  output logic             mem_mosi_out,
  output logic             mem_ss_n_out,
  input  wire logic        mem_miso_in,
  // gpio pins
  input  wire logic [2:0]  gpio_in,
  output logic [2:0]       gpio_out,
  output logic [2:0]       gpio_oe_out,
  output logic             bus_hold_en_out,
  output logic [2:0]       bus_hold_level_out,
  // analogue routing
  output logic [3:0]       dac0_route_out,
  output logic [3:0]       dac1_route_out,
  output logic [3:0]       out_pdn_out,
  output logic             adc_sel_out,
  output logic [1:0]       in_pdn_out,
  // transcoder path
  output logic [2:0]       src_sel_out,
  output logic [2:0]       dst_sel_out,
  output tpr_pkg::tpr_op_e ch1_op_out,
  output tpr_pkg::tpr_op_e ch2_op_out,
  output logic             in_filter_en_out,
  output logic             out_filter_en_out,
  output logic             law_sel_out,
  // audio words toward the codec engine
  output logic             audio_valid_out,
  output logic [15:0]      audio_data_out,
  input  wire logic        audio_ready_in
);
  tpr_pkg::tpr_state_e state_r;
  tpr_pkg::tpr_state_e state_nxt;
  logic [15:0] in_cfg_r, out_cfg_r, ctrl_r;
  logic [15:0] gain_r [4];
  logic [15:0] fi_cnt_r;
  logic [15:0] shift_r;
  logic [3:0]  bit_cnt_r;
  logic [1:0]  div_r;
  logic        miso_m_r, miso_r;
  logic [2:0]  gpio_m_r, gpio_s_r;
  logic        fifo_valid;
  logic [15:0] fifo_data;
  logic        fifo_ready;
  logic        pcm_take;

  // one-hot decoding of a two-bit selector, used for the source mask
  function automatic logic [2:0] tpr_onehot(input logic [1:0] sel);
    tpr_onehot = (sel == 2'h0) ? 3'h1 : (sel == 2'h1) ? 3'h2 : (sel == 2'h2) ? 3'h4 : 3'h0;
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      miso_m_r <= 1'b0;
      miso_r   <= 1'b0;
      gpio_m_r <= 3'h0;
      gpio_s_r <= 3'h0;
    end
    else
    begin
      miso_m_r <= mem_miso_in;
      miso_r   <= miso_m_r;
      gpio_m_r <= gpio_in;
      gpio_s_r <= gpio_m_r;
    end
  end

  // ----------------------------------------
  // boot sequencing
  // ----------------------------------------
  wire spi_tick  = (div_r == 2'(`TPR_SPI_HALF_CYC - 1));
  wire running   = (state_r == tpr_pkg::TPR_ST_RUN);
  wire mem_boot  = !link.boot_sel_high && link.boot_sel_low;
  wire fi_done   = (fi_cnt_r == 16'(FI_WORDS - 1));
  wire host_take = (state_r == tpr_pkg::TPR_ST_LOADHOST) && fifo_valid;
  // a word is complete on the rising edge that catches its sixteenth bit
  wire mem_word  = (state_r == tpr_pkg::TPR_ST_LOADMEM) && spi_tick && !mem_sclk_out && (bit_cnt_r == 4'hF);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      tpr_pkg::TPR_ST_STRAP:    state_nxt = mem_boot ? tpr_pkg::TPR_ST_LOADMEM : tpr_pkg::TPR_ST_LOADHOST;
      tpr_pkg::TPR_ST_LOADHOST: state_nxt = (host_take && fi_done) ? tpr_pkg::TPR_ST_RUN : state_r;
      tpr_pkg::TPR_ST_LOADMEM:  state_nxt = (mem_word && fi_done) ? tpr_pkg::TPR_ST_RUN : state_r;
      tpr_pkg::TPR_ST_RUN:      state_nxt = state_r;
      default:                  state_nxt = tpr_pkg::TPR_ST_STRAP;
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_r   <= tpr_pkg::TPR_ST_STRAP;
      fi_cnt_r  <= 16'h0000;
      div_r     <= 2'h0;
      bit_cnt_r <= 4'h0;
      shift_r   <= 16'h0000;
    end
    else
    begin
      state_r  <= state_nxt;
      div_r    <= spi_tick ? 2'h0 : div_r + 2'h1;
      if (host_take || mem_word)
      begin
        fi_cnt_r <= fi_cnt_r + 16'h0001;
      end
      // memory bits are caught on the rising sclk edge, msb of each word first
      if (state_r == tpr_pkg::TPR_ST_LOADMEM && spi_tick && !mem_sclk_out)
      begin
        shift_r   <= {shift_r[14:0], miso_r};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      else if (running && spi_tick && mem_sclk_out)
      begin
        // pcm out: reload a drained word at each word boundary, else shift
        shift_r   <= (bit_cnt_r == 4'hF && pcm_take) ? fifo_data : {shift_r[14:0], 1'b0};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  wire wr_ok = running && link.cfg_wr;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      in_cfg_r  <= `TPR_IN_CFG_RST;
      out_cfg_r <= `TPR_OUT_CFG_RST;
      ctrl_r    <= `TPR_CTRL_RST;
      for (int i = 0; i < 4; i++)
      begin
        gain_r[i] <= `TPR_GAIN_RST;
      end
    end
    else if (wr_ok)
    begin
      case (link.cfg_addr)
        `TPR_OFS_IN_CFG:    in_cfg_r  <= link.cfg_data;
        `TPR_OFS_IN_GAIN:   gain_r[0] <= link.cfg_data;
        `TPR_OFS_OUT_CFG:   out_cfg_r <= link.cfg_data;
        `TPR_OFS_LINE_GAIN: gain_r[1] <= link.cfg_data;
        `TPR_OFS_MON_GAIN:  gain_r[2] <= link.cfg_data;
        `TPR_OFS_SPK_GAIN:  gain_r[3] <= link.cfg_data;
        `TPR_OFS_CTRL:      ctrl_r    <= link.cfg_data;
        default:            ctrl_r    <= ctrl_r;
      endcase
    end
  end

  // ----------------------------------------
  // path decoding
  // ----------------------------------------
  wire              duplex   = ctrl_r[`TPR_CTRL_DUPLEX];
  wire [1:0]        op_raw   = ctrl_r[`TPR_CTRL_OP_LSB +: 2];
  wire [2:0]        port_req = ctrl_r[`TPR_CTRL_PORT_LSB +: 3];
  wire [2:0]        src_oh   = tpr_onehot(in_cfg_r[`TPR_IN_SRC_LSB +: 2]);
  // duplex keeps only the lowest requested port, since one stream cannot fan out there
  wire [2:0]        dup_port = port_req & (~port_req + 3'h1);
  wire [2:0]        dst_oh   = duplex ? dup_port : port_req;
  wire              port_err = duplex && (port_req != dup_port || port_req == 3'h0);
  wire              src_err  = (src_oh == 3'h0);
  tpr_pkg::tpr_op_e op1;
  tpr_pkg::tpr_op_e op2;
  assign op1 = (op_raw == 2'h3) ? tpr_pkg::TPR_OP_TRANS : tpr_pkg::tpr_op_e'(op_raw);
  assign op2 = (op1 == tpr_pkg::TPR_OP_ENC) ? tpr_pkg::TPR_OP_DEC :
               (op1 == tpr_pkg::TPR_OP_DEC) ? tpr_pkg::TPR_OP_ENC : tpr_pkg::TPR_OP_TRANS;
  wire enc_path = (op1 != tpr_pkg::TPR_OP_DEC);
  wire dec_path = (op1 != tpr_pkg::TPR_OP_ENC) || duplex;
  assign pcm_take = dst_oh[1] && fifo_valid;
  wire [2:0] hold_nxt = gpio_s_r;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      dac0_route_out     <= 4'h0;
      dac1_route_out     <= 4'h0;
      out_pdn_out        <= 4'hF;
      adc_sel_out        <= 1'b0;
      in_pdn_out         <= 2'h3;
      src_sel_out        <= 3'h0;
      dst_sel_out        <= 3'h0;
      ch1_op_out         <= tpr_pkg::TPR_OP_ENC;
      ch2_op_out         <= tpr_pkg::TPR_OP_DEC;
      in_filter_en_out   <= 1'b0;
      out_filter_en_out  <= 1'b0;
      law_sel_out        <= 1'b0;
      bus_hold_en_out    <= 1'b0;
      bus_hold_level_out <= 3'h0;
      link.cfg_err       <= 1'b0;
      link.dev_running   <= 1'b0;
    end
    else
    begin
      dac0_route_out     <= out_cfg_r[`TPR_OUT_DAC0_LSB +: 4];
      dac1_route_out     <= out_cfg_r[`TPR_OUT_DAC1_LSB +: 4];
      out_pdn_out        <= out_cfg_r[`TPR_OUT_PDN_LSB +: 4];
      adc_sel_out        <= in_cfg_r[`TPR_IN_ADC_SEL_BIT];
      in_pdn_out         <= in_cfg_r[`TPR_IN_PDN_LSB +: 2];
      src_sel_out        <= running ? src_oh : 3'h0;
      dst_sel_out        <= running ? dst_oh : 3'h0;
      ch1_op_out         <= op1;
      ch2_op_out         <= op2;
      in_filter_en_out   <= running && enc_path && src_oh[2];
      out_filter_en_out  <= running && dec_path && dst_oh[2];
      law_sel_out        <= ctrl_r[`TPR_CTRL_LAW_BIT];
      bus_hold_en_out    <= running && ctrl_r[`TPR_CTRL_HOLD_BIT];
      bus_hold_level_out <= hold_nxt;
      link.cfg_err       <= running && (port_err || src_err);
      link.dev_running   <= running;
    end
  end

  // ----------------------------------------
  // shared pins
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      mem_sclk_out <= 1'b0;
      mem_mosi_out <= 1'b0;
      mem_ss_n_out <= 1'b1;
    end
    else
    begin
      // while loading from memory the pins are an spi master, afterwards the pcm port
      if (spi_tick && (running || state_r == tpr_pkg::TPR_ST_LOADMEM))
      begin
        mem_sclk_out <= !mem_sclk_out;
      end
      mem_ss_n_out <= !(state_r == tpr_pkg::TPR_ST_LOADMEM);
      mem_mosi_out <= running ? shift_r[15] : 1'b0;
    end
  end

  assign gpio_out    = 3'h0;
  assign gpio_oe_out = 3'h0;

  // ----------------------------------------
  // word buffer
  // ----------------------------------------
  wire drain = host_take || (running && (dst_oh[1] ? (spi_tick && mem_sclk_out && bit_cnt_r == 4'hF)
                                                    : audio_ready_in));
  assign audio_valid_out = running && !dst_oh[1] && fifo_valid;
  assign audio_data_out  = fifo_data;

  tpr_fifo #(
    .WIDTH (16),
    .DEPTH (16)
  ) tpr_fifo_inst (
    .clock_in      (clock_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (link.word_valid),
    .in_data_in    (link.word_data),
    .in_ready_out  (fifo_ready),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (drain)
  );
  assign link.word_ready = fifo_ready;
endmodule
`default_nettype wire

// File: logic/tpr_host.sv
// host controller end: software register port driving configuration and words onto the link
`include "tpr_regs.svh"
`default_nettype none
module tpr_host (
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // software port
  input  wire logic [7:0]  sw_addr_in,
  input  wire logic [15:0] sw_wdata_in,
  input  wire logic        sw_wr_in,
  input  wire logic        sw_rd_in,
  output logic [15:0]      sw_rdata_out,
  // link to device
  tpr_link_if.host         link
);
  logic [7:0] target_r;
  logic [1:0] bootsel_r;
  wire        wr_target = sw_wr_in && (sw_addr_in == `TPR_H_TARGET);
  wire        wr_data   = sw_wr_in && (sw_addr_in == `TPR_H_WDATA);
  wire        wr_audio  = sw_wr_in && (sw_addr_in == `TPR_H_AUDIO) && !link.word_valid;
  wire [15:0] status    = {12'h000, link.word_valid, link.word_ready, link.cfg_err, link.dev_running};
  wire [15:0] rd_mux    = (sw_addr_in == `TPR_H_STATUS)  ? status :
                          (sw_addr_in == `TPR_H_TARGET)  ? {8'h00, target_r} :
                          (sw_addr_in == `TPR_H_BOOTSEL) ? {14'h0000, bootsel_r} : 16'h0000;

  assign link.boot_sel_high = bootsel_r[1];
  assign link.boot_sel_low  = bootsel_r[0];

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      target_r        <= 8'h00;
      bootsel_r       <= `TPR_H_BOOTSEL_RST;
      sw_rdata_out    <= 16'h0000;
      link.cfg_wr     <= 1'b0;
      link.cfg_addr   <= 8'h00;
      link.cfg_data   <= 16'h0000;
      link.word_valid <= 1'b0;
      link.word_data  <= 16'h0000;
    end
    else
    begin
      sw_rdata_out <= sw_rd_in ? rd_mux : 16'h0000;
      if (wr_target)
      begin
        target_r <= sw_wdata_in[7:0];
      end
      if (sw_wr_in && sw_addr_in == `TPR_H_BOOTSEL)
      begin
        bootsel_r <= sw_wdata_in[1:0];
      end
      link.cfg_wr <= wr_data;
      if (wr_data)
      begin
        link.cfg_addr <= target_r;
        link.cfg_data <= sw_wdata_in;
      end
      // a word is held until the device fifo takes it; writes meanwhile are dropped
      if (wr_audio)
      begin
        link.word_valid <= 1'b1;
        link.word_data  <= sw_wdata_in;
      end
      else if (link.word_ready)
      begin
        link.word_valid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/tpr_props.sv
// concurrent checks on the link and on the routing outputs of the device end
`default_nettype none
module tpr_props (
  // clock and reset
  input wire logic             clock_in,
  input wire logic             rstn_in,
  // link
  input wire logic             word_valid,
  input wire logic             word_ready,
  input wire logic [15:0]      word_data,
  input wire logic             dev_running,
  // device outputs
  input wire logic             mem_ss_n_out,
  input wire logic             mem_mosi_out,
  input wire logic [2:0]       gpio_oe_out,
  input wire logic             bus_hold_en_out,
  input wire logic [2:0]       src_sel_out,
  input wire logic [2:0]       dst_sel_out,
  input wire tpr_pkg::tpr_op_e ch1_op_out,
  input wire tpr_pkg::tpr_op_e ch2_op_out,
  input wire logic             in_filter_en_out,
  input wire logic             out_filter_en_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ch2_exp;

  // channel two always runs the reverse conversion
  assign ch2_exp = (ch1_op_out == tpr_pkg::TPR_OP_ENC) ? 2'h1 : (ch1_op_out == tpr_pkg::TPR_OP_DEC) ? 2'h0 : 2'h2;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  a_spi_boot_only: assert property (!mem_ss_n_out |-> !dev_running && !mem_mosi_out)
    else $error("serial select low while running");
  a_run_sticky: assert property (dev_running |=> dev_running)
    else $error("running dropped without reset");
  a_gpio_inputs: assert property (gpio_oe_out == 3'h0)
    else $error("gpio pin driven");
  a_hold_after_load: assert property (bus_hold_en_out |-> dev_running)
    else $error("bus hold before load");
  a_one_source: assert property ($countones(src_sel_out) <= 1)
    else $error("several sources");
  a_idle_paths: assert property (!dev_running |-> src_sel_out == 3'h0 && dst_sel_out == 3'h0)
    else $error("path selected before load");
  a_ch2_reverse: assert property (ch2_op_out == ch2_exp)
    else $error("channel two not reversed");
  a_in_filter_src: assert property (in_filter_en_out == (src_sel_out[2] && ch1_op_out != tpr_pkg::TPR_OP_DEC))
    else $error("input filter mismatch");
  a_out_filter_dst: assert property ((out_filter_en_out |-> dst_sel_out[2]) and
    (dst_sel_out[2] && ch1_op_out != tpr_pkg::TPR_OP_ENC |-> out_filter_en_out))
    else $error("output filter mismatch");
  a_word_held: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
    else $error("word dropped before taken");

  c_mem_boot: cover property (!mem_ss_n_out ##1 mem_ss_n_out);
  c_fifo_full: cover property (word_valid && !word_ready);
  c_trans: cover property (ch1_op_out == tpr_pkg::TPR_OP_TRANS);
  c_ana_src: cover property (src_sel_out[2]);
endmodule
`default_nettype wire

// File: tb/transcoder_path_router_tb.sv
// self-checking bench: host end and device end joined over the link
`include "tpr_regs.svh"
`default_nettype none
module transcoder_path_router_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clock_in = 1'b0;
  logic             rh_n = 1'b0;
  logic             rd_n = 1'b0;
  logic [7:0]       sw_addr_in = 8'h00;
  logic [15:0]      sw_wdata_in = 16'h0000;
  logic             sw_wr_in = 1'b0;
  logic             sw_rd_in = 1'b0;
  logic             mem_miso_in = 1'b0;
  logic [2:0]       gpio_in = 3'h0;
  logic             audio_ready_in = 1'b0;
  logic [15:0]      sw_rdata_out, audio_data_out, rd_v;
  logic             mem_sclk_out, mem_mosi_out, mem_ss_n_out, bus_hold_en_out, adc_sel_out;
  logic             in_filter_en_out, out_filter_en_out, law_sel_out, audio_valid_out;
  logic [2:0]       gpio_oe_out, bus_hold_level_out, src_sel_out, dst_sel_out;
  logic [3:0]       dac0_route_out, dac1_route_out, out_pdn_out;
  logic [1:0]       in_pdn_out;
  tpr_pkg::tpr_op_e ch1_op_out, ch2_op_out;
  int               n_fail = 0;
  int               samples_checked = 0;
  logic [15:0]      pcm_cap = 16'h0000;
  int               pcm_n = 0;

  tpr_link_if lk();
  tpr_host tpr_host_inst (.clock_in, .rstn_in(rh_n), .sw_addr_in, .sw_wdata_in, .sw_wr_in, .sw_rd_in,
    .sw_rdata_out, .link(lk));
  tpr_device #(.FI_WORDS(4)) tpr_device_inst (.clock_in, .rstn_in(rd_n), .link(lk), .mem_sclk_out,
    .mem_mosi_out, .mem_ss_n_out, .mem_miso_in, .gpio_in, .gpio_out(), .gpio_oe_out, .bus_hold_en_out,
    .bus_hold_level_out, .dac0_route_out, .dac1_route_out, .out_pdn_out, .adc_sel_out, .in_pdn_out,
    .src_sel_out, .dst_sel_out, .ch1_op_out, .ch2_op_out, .in_filter_en_out, .out_filter_en_out,
    .law_sel_out, .audio_valid_out, .audio_data_out, .audio_ready_in);
  tpr_props tpr_props_inst (.clock_in, .rstn_in(rd_n), .word_valid(lk.word_valid), .word_ready(lk.word_ready),
    .word_data(lk.word_data), .dev_running(lk.dev_running), .mem_ss_n_out, .mem_mosi_out, .gpio_oe_out,
    .bus_hold_en_out, .src_sel_out, .dst_sel_out, .ch1_op_out, .ch2_op_out, .in_filter_en_out,
    .out_filter_en_out);

  always #2 clock_in = ~clock_in;
  // serial memory stand-in: data changes on the falling serial clock
  always @(negedge mem_sclk_out) mem_miso_in <= ~mem_miso_in;
  // pcm receiver: catch the first word that starts with a one, msb first
  always @(posedge mem_sclk_out)
  begin
    if (pcm_n != 16 && (pcm_n != 0 || mem_mosi_out))
    begin
      pcm_cap <= {pcm_cap[14:0], mem_mosi_out};
      pcm_n   <= pcm_n + 1;
    end
  end

  // ------
  // tasks
  // ------
  task automatic results();
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_in);
    sw_addr_in <= a;
    sw_wdata_in <= d;
    sw_wr_in <= 1'b1;
    @(posedge clock_in);
    sw_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock_in);
    sw_addr_in <= a;
    sw_rd_in <= 1'b1;
    @(posedge clock_in);
    sw_rd_in <= 1'b0;
    #1;
    d = sw_rdata_out;
  endtask
  task automatic st(input logic [15:0] e);
    rd(`TPR_H_STATUS, rd_v);
    chk(rd_v, e);
  endtask
  // device register write: target then data, outputs settle within four edges
  task automatic cw(input logic [7:0] a, input logic [15:0] d);
    wr(`TPR_H_TARGET, {8'h00, a});
    wr(`TPR_H_WDATA, d);
    repeat (4) @(posedge clock_in);
    #1;
  endtask
  task automatic push(input logic [15:0] d);
    int i;
    wr(`TPR_H_AUDIO, d);
    for (i = 0; i < 40; i++)
    begin
      rd(`TPR_H_STATUS, rd_v);
      if (rd_v[3] === 1'b0)
        break;
    end
    if (i == 40)
    begin
      n_fail++;
      results();
    end
  endtask
  task automatic wait_run();
    int i;
    for (i = 0; i < 3000 && lk.dev_running !== 1'b1; i++)
      @(posedge clock_in);
    if (i == 3000)
    begin
      n_fail++;
      results();
    end
    #1;
  endtask

  // ------
  // main sequence
  // ------
  initial
  begin
    int k;
    logic [1:0] e1, e2;
    logic [2:0] es, pt;
    logic [15:0] ov [2];
    ov = '{16'h0A3F, 16'h05C1};
    repeat (6) @(posedge clock_in);
    rh_n <= 1'b1;
    rd_n <= 1'b1;
    rd(`TPR_H_BOOTSEL, rd_v);
    chk(rd_v, 16'h0003);
    st(16'h0004);
    rd(8'h07, rd_v);
    chk(rd_v, 16'h0000);
    chk({7'h00, out_pdn_out, in_pdn_out, ch2_op_out, mem_ss_n_out}, {7'h00, 4'hF, 2'h3, 2'h1, 1'b1});
    cw(`TPR_OFS_OUT_CFG, 16'h0123);
    chk({4'h0, out_pdn_out, dac1_route_out, dac0_route_out}, 16'h0F00);
    for (k = 0; k < 4; k++)
      push(16'h1000 + k[15:0]);
    wait_run();
    st(16'h0005);
    // fifo: fill with the drain stalled, then empty it in order
    for (k = 0; k < 16; k++)
      push(16'h2000 + k[15:0]);
    wr(`TPR_H_AUDIO, 16'h2010);
    st(16'h0009);
    @(posedge clock_in);
    audio_ready_in <= 1'b1;
    for (k = 0; k < 17; k++)
    begin
      #1;
      chk({15'h0000, audio_valid_out}, 16'h0001);
      chk(audio_data_out, 16'h2000 + k[15:0]);
      @(posedge clock_in);
    end
    #1;
    chk({15'h0000, audio_valid_out}, 16'h0000);
    for (k = 0; k < 2; k++)
    begin
      cw(`TPR_OFS_OUT_CFG, ov[k]);
      chk({4'h0, out_pdn_out, dac1_route_out, dac0_route_out}, ov[k] & 16'h0FFF);
    end
    for (k = 0; k < 4; k++)
    begin
      es = (k == 3) ? 3'h0 : 3'(1 << k);
      cw(`TPR_OFS_IN_CFG, {11'h000, 2'h2, k[0], k[1:0]});
      chk({9'h000, in_pdn_out, adc_sel_out, src_sel_out, in_filter_en_out}, {9'h000, 2'h2, k[0], es, k == 2});
    end
    cw(`TPR_OFS_IN_CFG, 16'h0002);
    for (k = 0; k < 4; k++)
    begin
      pt = k[0] ? 3'h4 : 3'h7;
      e1 = (k == 3) ? 2'h2 : k[1:0];
      e2 = (e1 == 2'h0) ? 2'h1 : (e1 == 2'h1) ? 2'h0 : 2'h2;
      cw(`TPR_OFS_CTRL, {8'h00, k[0], k[1], pt, k[1:0], k[0]});
      chk({5'h00, in_filter_en_out, dst_sel_out, out_filter_en_out, law_sel_out, bus_hold_en_out, ch1_op_out,
        ch2_op_out}, {5'h00, k != 1, pt, k != 0, k[1], k[0], e1, e2});
      st(16'h0005);
    end
    cw(`TPR_OFS_CTRL, 16'h0031);
    chk({13'h0000, dst_sel_out}, 16'h0002);
    st(16'h0007);
    push(16'hA5C3);
    for (k = 0; k < 200 && pcm_n != 16; k++)
      @(posedge clock_in);
    chk(pcm_cap, 16'hA5C3);
    for (k = 0; k < 2; k++)
    begin
      @(posedge clock_in);
      gpio_in <= k[0] ? 3'h2 : 3'h5;
      repeat (4) @(posedge clock_in);
      #1;
      chk({13'h0000, bus_hold_level_out}, k[0] ? 16'h0002 : 16'h0005);
    end
    // memory boot: select it, then restart the device end alone
    wr(`TPR_H_BOOTSEL, 16'h0001);
    rd(`TPR_H_BOOTSEL, rd_v);
    chk(rd_v, 16'h0001);
    @(posedge clock_in);
    rd_n <= 1'b0;
    repeat (2) @(posedge clock_in);
    rd_n <= 1'b1;
    repeat (4) @(posedge clock_in);
    #1;
    chk({14'h0000, mem_ss_n_out, lk.dev_running}, 16'h0000);
    wait_run();
    chk({15'h0000, mem_ss_n_out}, 16'h0001);
    st(16'h0005);
    results();
  end
endmodule
`default_nettype wire
